// *** hw/isl_pkg.sv ***
// shared types and constants for the i2c target engine
package isl_pkg;

    // bit counts within one byte on the wire
    localparam int unsigned BYTE_BITS    = 8;
    localparam logic [3:0]  BYTE_LAST    = 4'h8;
    localparam logic [3:0]  TX_LAST_FALL = 4'h7;

    // field positions inside an address byte
    localparam int unsigned RW_POS       = 0;
    localparam int unsigned ADDR_MSB     = 7;
    localparam int unsigned ADDR_LSB     = 1;

    // reset values
    localparam logic        CLOCK_RELEASE_RESET = 1'b1;
    localparam logic [7:0]  OWN_ADDRESS_RESET   = 8'h00;
    localparam logic [7:0]  BUFFER_RESET        = 8'h00;

    // line levels that the open-drain pins drive when enabled
    localparam logic        LINE_DRIVE_LOW      = 1'b0;

    // acknowledge encoding on sda
    localparam logic        ACK_LEVEL           = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TXACK
    } isl_state_t;

    // configuration levels from firmware
    typedef struct packed {
        logic enable;
        logic tenBit;
        logic addressHoldEnable;
        logic dataHoldEnable;
        logic stretchEnableBit;
        logic startIrqEnable;
        logic stopIrqEnable;
        logic targetCollisionDetectEnable;
        logic ackValueSelect;
    } isl_cfg_t;

    // status seen by firmware
    typedef struct packed {
        logic serialPortIrqFlag;
        logic clockReleaseControl;
        logic ackTimeStatus;
        logic bufferFullFlag;
        logic readWrite;
        logic dataAddress;
        logic startSeen;
        logic stopSeen;
        logic updateAddressFlag;
        logic ackReceivedStatus;
        logic busCollisionFlag;
    } isl_status_t;

endpackage : isl_pkg

// *** hw/isl_line_sync.sv ***
// scl/sda synchronisers with edge, start and stop detection
`timescale 1ns/100ps
module isl_line_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // raw bus lines
    input  wire logic sclIn,
    input  wire logic sdaIn,
    // sampled levels and events
    output logic      sclLevel,
    output logic      sdaLevel,
    output logic      sclRise,
    output logic      sclFall,
    output logic      startEvent,
    output logic      stopEvent
);
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] prev;
    logic [1:0] raw;

    assign raw = {sclIn, sdaIn};

    // idle bus is high, so sync chains reset high to avoid a false start
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (!nrst) begin
                stage1[i] <= 1'b1;
                stage2[i] <= 1'b1;
                prev[i]   <= 1'b1;
            end else begin
                stage1[i] <= raw[i];
                stage2[i] <= stage1[i];
                prev[i]   <= stage2[i];
            end
        end
    end

    assign sclLevel   = stage2[1];
    assign sdaLevel   = stage2[0];
    assign sclRise    = stage2[1] & ~prev[1];
    assign sclFall    = ~stage2[1] & prev[1];
    assign startEvent = stage2[1] & prev[1] & ~stage2[0] & prev[0];
    assign stopEvent  = stage2[1] & prev[1] & stage2[0] & ~prev[0];

endmodule : isl_line_sync

// *** hw/isl_shifter.sv ***
// shared receive/transmit shift register
`timescale 1ns/100ps
module isl_shifter #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadData,
    input  wire logic             shift,
    input  wire logic             shiftIn,
    // contents
    output logic      [WIDTH-1:0] data,
    output logic                  msb
);
    // a load beats a shift: firmware only loads while scl is held low
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            data <= '0;
        end else if (load) begin
            data <= loadData;
        end else if (shift) begin
            data <= {data[WIDTH-2:0], shiftIn};
        end
    end

    assign msb = data[WIDTH-1];

endmodule : isl_shifter

// *** hw/isl_engine.sv ***
// i2c target receive/transmit engine with clock stretching
`timescale 1ns/100ps
module isl_engine
    import isl_pkg::*;
#(
    parameter int unsigned WIDTH = BYTE_BITS
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // bus pins, open drain
    input  wire logic             sclIn,
    output logic                  sclOut,
    output logic                  sclOe,
    input  wire logic             sdaIn,
    output logic                  sdaOut,
    output logic                  sdaOe,
    // firmware configuration levels
    input  wire isl_cfg_t         cfg,
    // firmware strobes, one cycle each
    input  wire logic             irqFlagClear,
    input  wire logic             collisionFlagClear,
    input  wire logic             clockReleaseSet,
    input  wire logic             bufferRead,
    input  wire logic             bufferWrite,
    input  wire logic [WIDTH-1:0] bufferWriteData,
    input  wire logic             ownAddressWrite,
    input  wire logic [WIDTH-1:0] ownAddressWriteData,
    // firmware visible state
    output logic      [WIDTH-1:0] shiftBuffer,
    output logic      [WIDTH-1:0] ownAddressReg,
    output isl_status_t           status
);
    isl_state_t       state;
    logic [3:0]       bitCnt;
    logic             isAddr;
    logic             tenLow;
    logic             tenMatched;
    logic             ackHold;
    logic             ackIsRead;
    logic             ackIsHigh;
    logic             ackIsLow;
    logic             run;

    logic             sclLevel;
    logic             sdaLevel;
    logic             sclRise;
    logic             sclFall;
    logic             startEvent;
    logic             stopEvent;
    logic [WIDTH-1:0] shData;
    logic             shMsb;

    logic             rxDone;
    logic             ackDone;
    logic             txDone;
    logic             txAckDone;
    logic             collision;
    logic             rw;
    logic             addrMatch;
    logic             readMatch;
    logic             highWrite;
    logic             lowMiss;
    logic             ackBit;
    logic             holdNow;

    assign run = cfg.enable;

    isl_line_sync u_sync (
        .mclk       (mclk),
        .nrst       (nrst),
        .sclIn      (sclIn),
        .sdaIn      (sdaIn),
        .sclLevel   (sclLevel),
        .sdaLevel   (sdaLevel),
        .sclRise    (sclRise),
        .sclFall    (sclFall),
        .startEvent (startEvent),
        .stopEvent  (stopEvent)
    );

    isl_shifter #(.WIDTH(WIDTH)) u_shift (
        .mclk     (mclk),
        .nrst     (nrst),
        .load     (bufferWrite && state == ST_TX),
        .loadData (bufferWriteData),
        .shift    ((state == ST_RX && sclRise) || (state == ST_TX && sclFall && !txDone)),
        .shiftIn  (sdaLevel),
        .data     (shData),
        .msb      (shMsb)
    );

    // byte boundary events
    assign rxDone    = run && state == ST_RX && sclFall && bitCnt == BYTE_LAST;
    assign ackDone   = run && state == ST_ACK && sclFall;
    assign txDone    = run && state == ST_TX && sclFall && bitCnt == TX_LAST_FALL;
    assign txAckDone = run && state == ST_TXACK && sclFall;
    assign collision = run && cfg.targetCollisionDetectEnable && state == ST_TX
                       && sclRise && shMsb && !sdaLevel;

    // address decode on the just received byte
    always_comb begin
        rw        = shData[RW_POS];
        addrMatch = shData[ADDR_MSB:ADDR_LSB] == ownAddressReg[ADDR_MSB:ADDR_LSB];
        readMatch = 1'b0;
        highWrite = 1'b0;
        lowMiss   = 1'b0;
        if (cfg.tenBit && tenLow) begin
            addrMatch = shData == ownAddressReg;
            lowMiss   = !addrMatch;
        end else if (cfg.tenBit) begin
            readMatch = addrMatch && rw && tenMatched;
            highWrite = addrMatch && !rw;
            addrMatch = readMatch || highWrite;
        end else begin
            readMatch = addrMatch && rw;
        end
    end

    // hold decided at the eighth fall of a byte that will be answered
    assign holdNow = isAddr ? (cfg.addressHoldEnable && addrMatch && !lowMiss)
                            : cfg.dataHoldEnable;

    // firmware's choice only counts when the byte was held for it
    assign ackBit = ackHold ? cfg.ackValueSelect : ACK_LEVEL;

    // byte sequencing
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            state  <= ST_IDLE;
            bitCnt <= '0;
        end else if (stopEvent || collision) begin
            state  <= ST_IDLE;
            bitCnt <= '0;
        end else if (startEvent) begin
            state  <= ST_RX;
            bitCnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    bitCnt <= '0;
                end
                ST_RX: begin
                    if (rxDone) begin
                        state  <= (isAddr && !addrMatch) ? ST_IDLE : ST_ACK;
                        bitCnt <= '0;
                    end else if (sclRise) begin
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                ST_ACK: begin
                    if (ackDone) begin
                        if (ackBit != ACK_LEVEL) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ackIsRead ? ST_TX : ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (txDone) begin
                        state  <= ST_TXACK;
                        bitCnt <= '0;
                    end else if (sclFall) begin
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                ST_TXACK: begin
                    if (txAckDone) begin
                        state <= status.ackReceivedStatus == ACK_LEVEL ? ST_TX : ST_IDLE;
                    end
                end
                default: begin
                    state  <= ST_IDLE;
                    bitCnt <= '0;
                end
            endcase
        end
    end

    // address phase tracking, restart keeps a completed 10-bit match
    always_ff @(posedge mclk) begin
        if (!nrst || !run || stopEvent) begin
            isAddr     <= 1'b1;
            tenLow     <= 1'b0;
            tenMatched <= 1'b0;
        end else if (startEvent) begin
            isAddr <= 1'b1;
            tenLow <= 1'b0;
        end else if (rxDone && isAddr) begin
            if (cfg.tenBit && highWrite) begin
                tenLow <= 1'b1;
            end else begin
                isAddr     <= 1'b0;
                tenLow     <= 1'b0;
                tenMatched <= tenLow && addrMatch ? 1'b1 : tenMatched;
            end
        end
    end

    // what the pending acknowledge slot belongs to
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            ackHold   <= 1'b0;
            ackIsRead <= 1'b0;
            ackIsHigh <= 1'b0;
            ackIsLow  <= 1'b0;
        end else if (rxDone) begin
            ackHold   <= holdNow;
            ackIsRead <= isAddr && readMatch;
            ackIsHigh <= isAddr && cfg.tenBit && highWrite;
            ackIsLow  <= isAddr && tenLow;
        end
    end

    // own address; its write also lifts the update address hold
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ownAddressReg <= OWN_ADDRESS_RESET;
        end else if (ownAddressWrite) begin
            ownAddressReg <= ownAddressWriteData;
        end
    end

    // receive buffer and transmit data register
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            shiftBuffer <= BUFFER_RESET;
        end else if (bufferWrite) begin
            shiftBuffer <= bufferWriteData;
        end else if (rxDone && (!isAddr || addrMatch)) begin
            shiftBuffer <= shData;
        end
    end

    // buffer full: a new byte wins over a read in the same cycle
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.bufferFullFlag <= 1'b0;
        end else if ((rxDone && (!isAddr || addrMatch)) || bufferWrite) begin
            status.bufferFullFlag <= 1'b1;
        end else if (bufferRead) begin
            status.bufferFullFlag <= 1'b0;
        end
    end

    // interrupt flag: every hardware set wins over the firmware clear
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.serialPortIrqFlag <= 1'b0;
        end else if ((startEvent && cfg.startIrqEnable)
                     || (stopEvent && cfg.stopIrqEnable)
                     || (rxDone && isAddr && addrMatch && holdNow)
                     || (rxDone && !isAddr && holdNow)
                     || (rxDone && lowMiss)
                     || (ackDone && ackBit == ACK_LEVEL)
                     || txAckDone) begin
            status.serialPortIrqFlag <= 1'b1;
        end else if (irqFlagClear) begin
            status.serialPortIrqFlag <= 1'b0;
        end
    end

    // clock release: a hardware stretch request wins over a set in that cycle
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.clockReleaseControl <= CLOCK_RELEASE_RESET;
        end else if ((rxDone && holdNow && !lowMiss)
                     || (ackDone && ackBit == ACK_LEVEL
                         && (ackIsRead
                             || (cfg.stretchEnableBit && !ackIsHigh && !ackIsLow)))
                     || (txAckDone && status.ackReceivedStatus == ACK_LEVEL)) begin
            status.clockReleaseControl <= 1'b0;
        end else if (clockReleaseSet) begin
            status.clockReleaseControl <= 1'b1;
        end
    end

    // update address: set after a 10-bit address byte, cleared by an own address write
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.updateAddressFlag <= 1'b0;
        end else if ((ackDone && (ackIsHigh || ackIsLow) && ackBit == ACK_LEVEL)
                     || (rxDone && lowMiss)) begin
            status.updateAddressFlag <= 1'b1;
        end else if (ownAddressWrite) begin
            status.updateAddressFlag <= 1'b0;
        end
    end

    // ack time marks the span from the eighth to the ninth fall
    always_ff @(posedge mclk) begin
        if (!nrst || !run || ackDone || startEvent || stopEvent) begin
            status.ackTimeStatus <= 1'b0;
        end else if (rxDone && (!isAddr || addrMatch)) begin
            status.ackTimeStatus <= 1'b1;
        end
    end

    // transfer direction and byte type
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.readWrite   <= 1'b0;
            status.dataAddress <= 1'b0;
        end else if (rxDone && isAddr && addrMatch) begin
            status.readWrite   <= rw;
            status.dataAddress <= 1'b0;
        end else if (rxDone || txDone) begin
            status.dataAddress <= 1'b1;
        end
    end

    // start and stop seen
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.startSeen <= 1'b0;
            status.stopSeen  <= 1'b0;
        end else if (startEvent) begin
            status.startSeen <= 1'b1;
            status.stopSeen  <= 1'b0;
        end else if (stopEvent) begin
            status.startSeen <= 1'b0;
            status.stopSeen  <= 1'b1;
        end
    end

    // controller acknowledge latched at the ninth rise
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.ackReceivedStatus <= 1'b0;
        end else if (state == ST_TXACK && sclRise) begin
            status.ackReceivedStatus <= sdaLevel;
        end
    end

    // collision flag: detection wins over the firmware clear
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            status.busCollisionFlag <= 1'b0;
        end else if (collision) begin
            status.busCollisionFlag <= 1'b1;
        end else if (collisionFlagClear) begin
            status.busCollisionFlag <= 1'b0;
        end
    end

    // scl hold only grabs a line already low, so the controller's high time is kept
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            sclOe <= 1'b0;
        end else if (status.clockReleaseControl && !status.updateAddressFlag) begin
            sclOe <= 1'b0;
        end else if (!sclLevel) begin
            sclOe <= 1'b1;
        end
    end

    // sda drive: ack slot, or transmit bit while in a transmit byte
    always_ff @(posedge mclk) begin
        if (!nrst || !run) begin
            sdaOe <= 1'b0;
        end else begin
            case (state)
                ST_ACK:  sdaOe <= ackBit == ACK_LEVEL && status.clockReleaseControl;
                ST_TX:   sdaOe <= !shMsb && !txDone && !collision;
                default: sdaOe <= 1'b0;
            endcase
        end
    end

    // pins only ever pull low
    always_ff @(posedge mclk) begin
        sclOut <= LINE_DRIVE_LOW;
        sdaOut <= LINE_DRIVE_LOW;
    end

endmodule : isl_engine

// *** tb/isl_engine_assertions.sv ***
// port checker for the i2c target engine
`timescale 1ns/100ps
module isl_engine_assertions
    import isl_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // bus pins
    input wire logic        sclIn,
    input wire logic        sclOe,
    input wire logic        sdaIn,
    input wire logic        sdaOe,
    // firmware side
    input wire isl_cfg_t    cfg,
    input wire logic        irqFlagClear,
    input wire logic        clockReleaseSet,
    input wire logic        bufferRead,
    input wire logic        bufferWrite,
    input wire isl_status_t status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    read_clears_full_a: assert property (
        bufferRead && !bufferWrite |=> !status.bufferFullFlag)
        else $error("buffer full survived a read");
    // the sync chain lags two cycles, so scl must already read low there
    stretch_waits_low_a: assert property (
        $rose(sclOe) |-> !$past(sclIn) && !$past(sclIn, 2))
        else $error("scl pulled while still high");
    release_frees_scl_a: assert property (
        clockReleaseSet && !status.updateAddressFlag ##1 status.clockReleaseControl |=> !sclOe)
        else $error("scl held after release");
    clear_holds_scl_a: assert property (
        $fell(status.clockReleaseControl) |-> ##[0:3] sclOe)
        else $error("no stretch after clock release clear");
    bit_stable_a: assert property (
        sclIn [*6] |-> $stable(sdaOe) || status.busCollisionFlag)
        else $error("sda moved while scl high");
    irq_sticky_a: assert property (
        status.serialPortIrqFlag && !irqFlagClear && cfg.enable |=> status.serialPortIrqFlag)
        else $error("irq flag dropped by itself");
    start_quiet_a: assert property (
        $fell(sdaIn) && sclIn && !cfg.startIrqEnable && !status.serialPortIrqFlag
        |-> ##[2:5] (status.startSeen && !status.serialPortIrqFlag))
        else $error("start seen wrong");
    stop_quiet_a: assert property (
        $rose(sdaIn) && sclIn && !cfg.stopIrqEnable && !status.serialPortIrqFlag
        |-> ##[2:5] (status.stopSeen && !status.serialPortIrqFlag))
        else $error("stop seen wrong");
endmodule : isl_engine_assertions

// *** tb/isl_ctl_model.sv ***
// behavioural bus controller that clocks the target
`timescale 1ns/100ps
module isl_ctl_model (
    // clock and wires
    input  wire logic mclk,
    input  wire logic sclW,
    input  wire logic sdaW,
    // open-drain pulls, low pulls the wire
    output logic      sclM,
    output logic      sdaM
);
    int stall = 0;
    // counts stretched clocks that never came back; the bench compares it
    int waitMiss = 0;
    initial begin
        sclM = 1'b1;
        sdaM = 1'b1;
    end
    // half of the 64 ns period; stall makes a slow controller
    task automatic half;
        repeat (8 + stall) @(posedge mclk);
    endtask : half
    // a stretched clock is waited for, but never forever
    task automatic bitx(input logic b, output logic r);
        int n;
        n = 0;
        sdaM <= b;
        half();
        sclM <= 1'b1;
        @(posedge mclk);
        while (!sclW && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 5000)
            waitMiss++;
        half();
        r = sdaW;
        sclM <= 1'b0;
        @(posedge mclk);
    endtask : bitx
    task automatic byte8(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
    endtask : byte8
    task automatic start;
        sdaM <= 1'b1;
        half();
        sclM <= 1'b1;
        half();
        sdaM <= 1'b0;
        half();
        sclM <= 1'b0;
        @(posedge mclk);
    endtask : start
    task automatic stop;
        sdaM <= 1'b0;
        half();
        sclM <= 1'b1;
        half();
        sdaM <= 1'b1;
        half();
    endtask : stop
endmodule : isl_ctl_model

// *** tb/testbench.sv ***
// self-checking bench for the i2c target engine
`timescale 1ns/100ps
module testbench;
    import isl_pkg::*;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    isl_cfg_t    cfg = '0;
    logic [5:0]  stb = '0;
    logic [7:0]  wdat = '0;
    logic        sclOe, sdaOe, sclW, sdaW, sclM, sdaM, a, sclO, sdaO;
    logic [7:0]  sb, oa, d, q;
    isl_status_t st;
    logic [7:0]  expq[$];
    int          n_mismatch = 0;
    int          cmp_count = 0;
    integer      seed = 32'h858c91ad;
    always #2 mclk = ~mclk;
    // both lines have pull-ups: released means high
    // the driven level only reaches the wire while enabled
    assign sclW = sclM & (sclOe ? sclO : 1'b1);
    assign sdaW = sdaM & (sdaOe ? sdaO : 1'b1);
    isl_ctl_model ctl (.mclk(mclk), .sclW(sclW), .sdaW(sdaW), .sclM(sclM), .sdaM(sdaM));
    isl_engine dut (
        .mclk(mclk), .nrst(nrst), .sclIn(sclW), .sclOut(sclO), .sclOe(sclOe),
        .sdaIn(sdaW), .sdaOut(sdaO), .sdaOe(sdaOe), .cfg(cfg),
        .irqFlagClear(stb[0]), .clockReleaseSet(stb[1]), .bufferRead(stb[2]),
        .bufferWrite(stb[3]), .ownAddressWrite(stb[4]), .collisionFlagClear(stb[5]),
        .bufferWriteData(wdat), .ownAddressWriteData(wdat),
        .shiftBuffer(sb), .ownAddressReg(oa), .status(st));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : chk
    // strobes: 0 irq clear, 1 release, 2 read, 3 write, 4 own address, 5 collision clear
    task automatic pulse(input int k);
        stb <= 6'h01 << k;
        @(posedge mclk);
        stb <= '0;
        @(posedge mclk);
    endtask : pulse
    task automatic settle;
        repeat (6) @(posedge mclk);
    endtask : settle
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        cfg <= '{enable: 1'b1, stretchEnableBit: 1'b1, default: 1'b0};
        wdat <= 8'h5a;
        settle();
        chk({st, sb}, {11'h200, BUFFER_RESET});
        pulse(4);
        chk(oa, 8'h5a);
        ctl.start();
        chk({st.startSeen, st.serialPortIrqFlag}, 2'b10);
        ctl.byte8(8'h5a, q);
        ctl.bitx(1'b1, a);
        settle();
        chk({a, st.serialPortIrqFlag, st.clockReleaseControl, sclOe, sb}, {4'h5, 8'h5a});
        pulse(2);
        chk(st.bufferFullFlag, 1'b0);
        pulse(0);
        pulse(1);
        d = 8'($random(seed));
        ctl.byte8(d, q);
        ctl.bitx(1'b1, a);
        settle();
        chk({a, st.dataAddress, st.clockReleaseControl, sb}, {3'b010, d});
        pulse(0);
        pulse(1);
        ctl.stop();
        settle();
        chk({st.stopSeen, st.serialPortIrqFlag}, 2'b10);
        $display("test write with stretch done");
        cfg <= '{enable: 1'b1, addressHoldEnable: 1'b1, dataHoldEnable: 1'b1, default: 1'b0};
        ctl.stall = 12;
        ctl.start();
        ctl.byte8(8'h5a, q);
        settle();
        chk({st.serialPortIrqFlag, st.clockReleaseControl, st.ackTimeStatus, sclOe}, 4'hb);
        pulse(0);
        pulse(1);
        ctl.bitx(1'b1, a);
        settle();
        chk({a, st.serialPortIrqFlag, st.ackTimeStatus}, 3'b010);
        pulse(0);
        ctl.byte8(d, q);
        settle();
        chk({st.serialPortIrqFlag, st.clockReleaseControl, sb}, {2'b10, d});
        cfg.ackValueSelect <= 1'b1;
        pulse(0);
        pulse(1);
        ctl.bitx(1'b1, a);
        settle();
        chk({a, st.serialPortIrqFlag}, 2'b10);
        ctl.stop();
        ctl.stall = 0;
        $display("test hold modes done");
        cfg <= '{enable: 1'b1, default: 1'b0};
        ctl.start();
        ctl.byte8(8'h5b, q);
        ctl.bitx(1'b1, a);
        settle();
        chk({a, st.readWrite, st.clockReleaseControl, sclOe, sb}, {4'h5, 8'h5b});
        for (int k = 0; k < 2; k++) begin
            expq.push_back(8'($random(seed)));
            wdat <= expq[0];
            pulse(0);
            pulse(3);
            pulse(1);
            ctl.byte8(8'hff, q);
            ctl.bitx(k[0], a);
            settle();
            chk({q, st.ackReceivedStatus, st.serialPortIrqFlag, st.clockReleaseControl, sclOe},
                {expq.pop_front(), k[0], 1'b1, k[0], ~k[0]});
        end
        ctl.stop();
        $display("test transmit done");
        cfg.targetCollisionDetectEnable <= 1'b1;
        ctl.start();
        ctl.byte8(8'h5b, q);
        ctl.bitx(1'b1, a);
        settle();
        wdat <= 8'hff;
        pulse(3);
        pulse(1);
        ctl.byte8(8'h7f, q);
        chk({st.busCollisionFlag, sdaOe, sclOe}, 3'b100);
        pulse(5);
        chk(st.busCollisionFlag, 1'b0);
        ctl.stop();
        $display("test collision done");
        cfg <= '{enable: 1'b1, tenBit: 1'b1, default: 1'b0};
        wdat <= 8'hf6;
        pulse(4);
        pulse(0);
        ctl.start();
        ctl.byte8(8'hf6, q);
        ctl.bitx(1'b1, a);
        settle();
        chk({a, st.updateAddressFlag, st.serialPortIrqFlag, sclOe}, 4'h7);
        // only rewritten once the ack slot is over
        wdat <= 8'h3c;
        pulse(4);
        settle();
        chk({st.updateAddressFlag, sclOe}, 2'b00);
        pulse(0);
        pulse(2);
        ctl.byte8(8'h00, q);
        settle();
        chk({st.serialPortIrqFlag, st.updateAddressFlag, st.bufferFullFlag}, 3'b110);
        wdat <= 8'hf6;
        pulse(4);
        ctl.bitx(1'b1, a);
        ctl.stop();
        $display("test ten bit done");
        chk(ctl.waitMiss, 0);
        end_sim();
    end
endmodule : testbench
bind isl_engine isl_engine_assertions asrt (.mclk, .nrst, .sclIn, .sclOe, .sdaIn, .sdaOe, .cfg,
    .irqFlagClear, .clockReleaseSet, .bufferRead, .bufferWrite, .status);
